/* hw/rofs_defines.svh */
/*
 * Register offsets, reset values and field positions of the relay output
 * function selector.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ROFS_DEFINES_SVH
`define ROFS_DEFINES_SVH

// Register byte offsets
`define ROFS_OFF_SEL_ONE 8'h00
`define ROFS_OFF_SEL_TWO 8'h04
`define ROFS_OFF_MONITOR 8'h08
`define ROFS_OFF_DET_FREQ 8'h0c
`define ROFS_OFF_DET_BAND 8'h10
`define ROFS_OFF_BRK_LEVEL 8'h14

// Reset values, frequencies in 0.01 Hz steps
`define ROFS_RST_SEL_ONE 6'h1d
`define ROFS_RST_SEL_TWO 6'h0e
`define ROFS_RST_DET_FREQ 16'h0bb8
`define ROFS_RST_DET_BAND 16'h03e8
`define ROFS_RST_BRK_LEVEL 16'hffff

// Highest selection code accepted on a write
`define ROFS_SEL_MAX 6'h2d

// Monitor field positions
`define ROFS_MON_RELAY_ONE 0
`define ROFS_MON_RELAY_TWO 1

`endif

/* hw/rofs_pkg.sv */
/*
 * Types of the relay output function selector: status bundle, selection
 * codes and detector state.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rofs_pkg;

   // Drive conditions offered to the selector
   typedef struct packed {
      logic overload;
      logic inverse_time_overload_fault;
      logic underload_warn;
      logic fan_warn;
      logic stall;
      logic over_voltage;
      logic low_voltage;
      logic over_heat;
      logic command_lost;
      logic run_cmd;
      logic output_active;
      logic dc_braking;
      logic accelerating;
      logic decelerating;
      logic drive_line;
      logic comm_line;
      logic speed_search;
      logic regenerating;
      logic ready;
   } rofs_status_t;

   // Selection codes handled by this block
   typedef enum logic [5:0] {
      ROFS_NONE = 6'h00,
      ROFS_ACC_DEC_FDET = 6'h04,
      ROFS_OVERLOAD = 6'h05,
      ROFS_INV_OVERLOAD = 6'h06,
      ROFS_UNDERLOAD = 6'h07,
      ROFS_FAN_WARN = 6'h08,
      ROFS_STALL = 6'h09,
      ROFS_OVER_VOLT = 6'h0a,
      ROFS_LOW_VOLT = 6'h0b,
      ROFS_OVER_HEAT = 6'h0c,
      ROFS_CMD_LOST = 6'h0d,
      ROFS_RUN = 6'h0e,
      ROFS_STOP = 6'h0f,
      ROFS_STEADY = 6'h10,
      ROFS_DRIVE_LINE = 6'h11,
      ROFS_COMM_LINE = 6'h12,
      ROFS_SPEED_SEARCH = 6'h13,
      ROFS_REGEN = 6'h15,
      ROFS_READY = 6'h16,
      ROFS_LOW_SPEED = 6'h17
   } rofs_code_t;

   // Accel and decel frequency detector state
   typedef enum logic {
      ROFS_FDET_OFF = 1'b0,
      ROFS_FDET_ON = 1'b1
   } rofs_fdet_t;

endpackage

/* hw/rofs_relay_select.sv */
/*
 * Relay output function selector: two relays, each driven by one drive
 * condition picked by its own selection code, plus braking resistor enable.
 * Assumes status, frequencies and DC voltage come from logic on sys_clk,
 * and a register master with one-cycle strobes and no wait states.
 */
// Added by the designer: the address-and-strobe port and the address map.
// Summary of operation
// R1: Each relay has its own selection code, range 0 to 45.
// R2: Detection frequency and band width are separate writable settings.
// R3: Monitor register reads the present state of both relays.
// R4: Code 4 accelerating: on when output frequency reaches detection frequency.
// R5: Code 4 decelerating: on while frequency exceeds detection minus half band.
// R6: Code 5 follows motor overload.
// R7: Code 6 follows the inverse-time overload fault.
// R8: Code 7 follows the underload warning.
// R9: Code 8 follows the cooling fan warning.
// R10: Code 9 on when the motor is overloaded and stalled.
// R11: Code 10 follows DC link over-voltage.
// R12: Code 11 follows DC link low voltage.
// R13: Code 12 follows drive over-temperature.
// R14: Code 13 follows loss of analog or serial command.
// R15: Code 14 on with run command and output voltage, off in DC braking.
// R16: Code 15 on with run command off and no output voltage.
// R17: Code 16 on while running neither accelerating nor decelerating.
// R18: Code 17 on while the motor is fed from the drive output.
// R19: Code 18 on while the motor is fed from the utility line.
// R20: Code 19 on while speed search runs.
// R21: Code 21 on while the motor regenerates.
// R22: Braking resistor enabled only when running and DC voltage above threshold.
// R23: Code 22 on while standing by, ready for an external run command.
// R24: Code 23 on while output frequency is below detection frequency less half band.
// R25: Undefined codes, code 20 among them, hold the relay off.
`timescale 1ns/10ps
`default_nettype none
`include "rofs_defines.svh"

module rofs_relay_select #(
   parameter int FW = 16,
   parameter int AW = 8,
   parameter int DW = 16
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   // Drive conditions
   input wire rofs_pkg::rofs_status_t status,
   input wire logic [FW-1:0] output_freq,
   input wire logic [FW-1:0] dc_voltage,
   // Outputs to relays and braking resistor
   output logic [1:0] relay_out,
   output logic brake_enable
);
   import rofs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [5:0] relay_one_function_select;
   logic [5:0] relay_two_function_select;
   logic [FW-1:0] detect_frequency_setting;
   logic [FW-1:0] detect_band_width_setting;
   logic [FW-1:0] brake_level;
   logic [DW-1:0] next_rdata;
   logic [1:0] relay_state_monitor;

   // Write strobes per register
   wire logic wr_sel_one = reg_wr && (reg_addr == `ROFS_OFF_SEL_ONE);
   wire logic wr_sel_two = reg_wr && (reg_addr == `ROFS_OFF_SEL_TWO);
   wire logic wr_det_freq = reg_wr && (reg_addr == `ROFS_OFF_DET_FREQ);
   wire logic wr_det_band = reg_wr && (reg_addr == `ROFS_OFF_DET_BAND);
   wire logic wr_brk_level = reg_wr && (reg_addr == `ROFS_OFF_BRK_LEVEL);
   // Codes above the top of the range are refused
   wire logic code_ok = (reg_wdata[5:0] <= `ROFS_SEL_MAX) && (reg_wdata[DW-1:6] == '0);

   // Relay selection codes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         relay_one_function_select <= `ROFS_RST_SEL_ONE;
         relay_two_function_select <= `ROFS_RST_SEL_TWO;
      end else if (ce) begin
         if (wr_sel_one && code_ok) begin
            relay_one_function_select <= reg_wdata[5:0]; // R1
         end
         if (wr_sel_two && code_ok) begin
            relay_two_function_select <= reg_wdata[5:0]; // R1
         end
      end
   end

   // Detection and braking settings
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         detect_frequency_setting <= `ROFS_RST_DET_FREQ;
         detect_band_width_setting <= `ROFS_RST_DET_BAND;
         brake_level <= `ROFS_RST_BRK_LEVEL;
      end else if (ce) begin
         if (wr_det_freq) begin
            detect_frequency_setting <= reg_wdata[FW-1:0]; // R2
         end
         if (wr_det_band) begin
            detect_band_width_setting <= reg_wdata[FW-1:0]; // R2
         end
         if (wr_brk_level) begin
            brake_level <= reg_wdata[FW-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode

   assign relay_state_monitor = relay_out;

   // Unmapped addresses read as zero
   always_comb begin
      next_rdata = '0;
      if (reg_addr == `ROFS_OFF_SEL_ONE) begin
         next_rdata[5:0] = relay_one_function_select;
      end else if (reg_addr == `ROFS_OFF_SEL_TWO) begin
         next_rdata[5:0] = relay_two_function_select;
      end else if (reg_addr == `ROFS_OFF_MONITOR) begin
         next_rdata[1:0] = relay_state_monitor; // R3
      end else if (reg_addr == `ROFS_OFF_DET_FREQ) begin
         next_rdata[FW-1:0] = detect_frequency_setting;
      end else if (reg_addr == `ROFS_OFF_DET_BAND) begin
         next_rdata[FW-1:0] = detect_band_width_setting;
      end else if (reg_addr == `ROFS_OFF_BRK_LEVEL) begin
         next_rdata[FW-1:0] = brake_level;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? next_rdata : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency detection

   // Level of detection frequency less half band, floored at zero
   wire logic [FW-1:0] half_band = detect_band_width_setting >> 1;
   wire logic [FW-1:0] low_level = (detect_frequency_setting > half_band) ?
      (detect_frequency_setting - half_band) : '0;
   wire logic at_detect = output_freq >= detect_frequency_setting;
   wire logic above_low = output_freq > low_level;

   rofs_fdet_t fdet_state;
   rofs_fdet_t next_fdet_state;

   // Accel uses the full level, decel the lowered one; otherwise hold
   always_comb begin
      next_fdet_state = fdet_state;
      case (fdet_state)
         ROFS_FDET_OFF: begin
            if (status.accelerating && at_detect) begin
               next_fdet_state = ROFS_FDET_ON; // R4
            end else if (status.decelerating && above_low) begin
               next_fdet_state = ROFS_FDET_ON; // R5
            end
         end
         ROFS_FDET_ON: begin
            if (status.accelerating && !at_detect) begin
               next_fdet_state = ROFS_FDET_OFF; // R4
            end else if (status.decelerating && !above_low) begin
               next_fdet_state = ROFS_FDET_OFF; // R5
            end
         end
         default: begin
            next_fdet_state = ROFS_FDET_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fdet_state <= ROFS_FDET_OFF;
      end else if (ce) begin
         fdet_state <= next_fdet_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Condition table, one bit per selection code

   logic [63:0] cond_vec;

   // Codes left at zero keep their relay off
   always_comb begin
      cond_vec = '0; // R25
      cond_vec[ROFS_ACC_DEC_FDET] = (next_fdet_state == ROFS_FDET_ON); // R4
      cond_vec[ROFS_OVERLOAD] = status.overload; // R6
      cond_vec[ROFS_INV_OVERLOAD] = status.inverse_time_overload_fault; // R7
      cond_vec[ROFS_UNDERLOAD] = status.underload_warn; // R8
      cond_vec[ROFS_FAN_WARN] = status.fan_warn; // R9
      cond_vec[ROFS_STALL] = status.overload && status.stall; // R10
      cond_vec[ROFS_OVER_VOLT] = status.over_voltage; // R11
      cond_vec[ROFS_LOW_VOLT] = status.low_voltage; // R12
      cond_vec[ROFS_OVER_HEAT] = status.over_heat; // R13
      cond_vec[ROFS_CMD_LOST] = status.command_lost; // R14
      cond_vec[ROFS_RUN] = status.run_cmd && status.output_active &&
         !status.dc_braking; // R15
      cond_vec[ROFS_STOP] = !status.run_cmd && !status.output_active; // R16
      cond_vec[ROFS_STEADY] = status.output_active && !status.accelerating &&
         !status.decelerating; // R17
      cond_vec[ROFS_DRIVE_LINE] = status.drive_line; // R18
      cond_vec[ROFS_COMM_LINE] = status.comm_line; // R19
      cond_vec[ROFS_SPEED_SEARCH] = status.speed_search; // R20
      cond_vec[ROFS_REGEN] = status.regenerating; // R21
      cond_vec[ROFS_READY] = status.ready; // R23
      cond_vec[ROFS_LOW_SPEED] = output_freq < low_level; // R24
   end

   ////////////////////////////////////////////////////////////////////////
   // Relay drivers

   wire logic [5:0] sel_code [2];
   assign sel_code[0] = relay_one_function_select;
   assign sel_code[1] = relay_two_function_select;

   wire logic [1:0] next_relay;

   // Each relay picks its own condition
   for (genvar gi = 0; gi < 2; gi++) begin : g_relay
      assign next_relay[gi] = cond_vec[sel_code[gi]]; // R1
   end

   // Relay coils in one process, so each bit has a single driver
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         relay_out <= 2'h0;
      end else if (ce) begin
         relay_out <= next_relay; // R1
      end
   end

   // Braking resistor only while running above threshold
   wire logic next_brake = status.output_active && (dc_voltage > brake_level);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         brake_enable <= 1'b0;
      end else if (ce) begin
         brake_enable <= next_brake; // R22
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   wire rofs_code_t code_one = rofs_code_t'(relay_one_function_select);

   a_overload_relay: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
      ce && code_one == ROFS_OVERLOAD && status.overload |=> relay_out[0])
      else $error("overload code did not raise relay one");

   a_stall_needs_both: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
      ce && code_one == ROFS_STALL && !status.overload |=> !relay_out[0])
      else $error("stall relay on without overload");

   a_run_braking_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
      ce && code_one == ROFS_RUN && status.dc_braking |=> !relay_out[0])
      else $error("run relay on during dc braking");

   a_stop_relay_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
      ce && code_one == ROFS_STOP && !status.run_cmd && !status.output_active
      |=> relay_out[0])
      else $error("stop relay not on when stopped");

   a_undefined_code_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R25
      ce && relay_two_function_select == 6'h14 |=> !relay_out[1])
      else $error("code twenty drove relay two");

   a_fdet_accel_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
      ce && code_one == ROFS_ACC_DEC_FDET && status.accelerating && at_detect
      |=> relay_out[0])
      else $error("accel detect missed");

   a_fdet_decel_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
      ce && code_one == ROFS_ACC_DEC_FDET && status.decelerating &&
      !status.accelerating && !above_low |=> !relay_out[0])
      else $error("decel detect stayed on");

   a_low_speed_relay: assert property (@(posedge sys_clk) disable iff (!rst_n) // R24
      ce && code_one == ROFS_LOW_SPEED
      |=> relay_out[0] == ($past(output_freq) < $past(low_level)))
      else $error("low speed relay wrong");

   a_brake_gated_run: assert property (@(posedge sys_clk) disable iff (!rst_n) // R22
      ce && !status.output_active |=> !brake_enable)
      else $error("brake enabled while not running");

   a_monitor_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
      ce && reg_rd && reg_addr == `ROFS_OFF_MONITOR
      |=> reg_rdata == {{(DW-2){1'b0}}, $past(relay_out)})
      else $error("monitor read mismatch");

   a_select_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
      ce && wr_sel_one && !code_ok |=> $stable(relay_one_function_select))
      else $error("out of range code accepted");

   a_freq_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
      ce && wr_det_band |=> detect_band_width_setting == $past(reg_wdata[FW-1:0]))
      else $error("band write lost");

   a_inv_overload_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
      ce && code_one == ROFS_INV_OVERLOAD && status.inverse_time_overload_fault
      |=> relay_out[0])
      else $error("inverse-time overload code did not raise relay one");

   a_underload_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
      ce && code_one == ROFS_UNDERLOAD && !status.underload_warn |=> !relay_out[0])
      else $error("underload relay on without warning");

   a_fan_warn_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
      ce && code_one == ROFS_FAN_WARN && status.fan_warn |=> relay_out[0])
      else $error("fan warning did not raise relay one");

   a_over_volt_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
      ce && code_one == ROFS_OVER_VOLT && status.over_voltage |=> relay_out[0])
      else $error("over-voltage did not raise relay one");

   a_low_volt_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
      ce && code_one == ROFS_LOW_VOLT && status.low_voltage |=> relay_out[0])
      else $error("low voltage did not raise relay one");

   a_over_heat_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
      ce && code_one == ROFS_OVER_HEAT && status.over_heat |=> relay_out[0])
      else $error("over-temperature did not raise relay one");

   a_cmd_lost_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
      ce && code_one == ROFS_CMD_LOST && status.command_lost |=> relay_out[0])
      else $error("command loss did not raise relay one");

   a_steady_accel_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
      ce && code_one == ROFS_STEADY && status.accelerating |=> !relay_out[0])
      else $error("steady relay on while accelerating");

   a_drive_line_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
      ce && code_one == ROFS_DRIVE_LINE && status.drive_line |=> relay_out[0])
      else $error("drive line did not raise relay one");

   a_comm_line_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
      ce && code_one == ROFS_COMM_LINE && !status.comm_line |=> !relay_out[0])
      else $error("utility line relay on without utility feed");

   a_speed_search_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R20
      ce && code_one == ROFS_SPEED_SEARCH && status.speed_search |=> relay_out[0])
      else $error("speed search did not raise relay one");

   a_regen_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R21
      ce && code_one == ROFS_REGEN && status.regenerating |=> relay_out[0])
      else $error("regeneration did not raise relay one");

   a_ready_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R23
      ce && code_one == ROFS_READY && status.ready |=> relay_out[0])
      else $error("ready did not raise relay one");

   c_run_relay: cover property (@(posedge sys_clk) disable iff (!rst_n)
      code_one == ROFS_RUN ##1 relay_out[0] ##1 !relay_out[0]);

   c_fdet_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
      fdet_state == ROFS_FDET_ON ##[1:50] fdet_state == ROFS_FDET_OFF);

   c_brake_on: cover property (@(posedge sys_clk) disable iff (!rst_n)
      !brake_enable ##1 brake_enable);

   c_both_relays: cover property (@(posedge sys_clk) disable iff (!rst_n)
      relay_out == 2'h3);

endmodule // rofs_relay_select
`default_nettype wire

/* bench/rofs_relay_model.sv */
/*
 * Model of the two external relays: each contact follows its coil after a
 * two-cycle pull-in, and drops to open in reset.
 * Assumes coils are driven active high from logic on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module rofs_relay_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Coils from the selector
   input wire logic [1:0] coil,
   // Contacts seen by the load
   output logic [1:0] contact
);
   logic [1:0] stage;
   // Two-stage pull-in, so contacts follow the coil two cycles late, one-cycle glitches included
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage <= 2'h0;
         contact <= 2'h0;
      end else begin
         stage <= coil;
         contact <= stage;
      end
   end
endmodule // rofs_relay_model
`default_nettype wire

/* bench/tb.sv */
/*
 * Self-checking bench of the relay output function selector.
 * Assumes the package, the selector and the relay model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rofs_pkg::*;
   logic sys_clk, rst_n, ce, reg_wr, reg_rd, brake_enable;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, output_freq, dc_voltage, rd, lvl, det_v, band_v;
   rofs_status_t status, s;
   logic [1:0] relay_out, contact, e;
   logic [5:0] c2;
   logic [18:0] t4 [8];
   int failures, num_checks, cyc;

   rofs_relay_select rofs_relay_select_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .status(status), .output_freq(output_freq),
      .dc_voltage(dc_voltage), .relay_out(relay_out), .brake_enable(brake_enable));
   rofs_relay_model rofs_relay_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .coil(relay_out), .contact(contact));

   ////////////////////////////////////////////////////////////////////////////
   // Expected relay state of one code, code 4 excluded
   function automatic logic exp_rel(input logic [5:0] c, input rofs_status_t x,
      input logic [15:0] f);
      logic [15:0] z;
      z = (det_v > band_v / 2) ? det_v - band_v / 2 : 16'h0000;
      case (c)
         6'd5: return x.overload;
         6'd6: return x.inverse_time_overload_fault;
         6'd7: return x.underload_warn;
         6'd8: return x.fan_warn;
         6'd9: return x.overload & x.stall;
         6'd10: return x.over_voltage;
         6'd11: return x.low_voltage;
         6'd12: return x.over_heat;
         6'd13: return x.command_lost;
         6'd14: return x.run_cmd & x.output_active & !x.dc_braking;
         6'd15: return !x.run_cmd & !x.output_active;
         6'd16: return x.output_active & !x.accelerating & !x.decelerating;
         6'd17: return x.drive_line;
         6'd18: return x.comm_line;
         6'd19: return x.speed_search;
         6'd21: return x.regenerating;
         6'd22: return x.ready;
         6'd23: return f < z;
         default: return 1'b0;
      endcase
   endfunction

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read, data taken in the following cycle
   task automatic rdr(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask

   // Drive conditions, then let the registered relays settle
   task automatic apply(input rofs_status_t x, input logic [15:0] f, input logic [15:0] v);
      @(posedge sys_clk);
      status <= x;
      output_freq <= f;
      dc_voltage <= v;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   // Verdict and end of run
   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         $display("[FAIL] %0t timeout", $time);
         complete_run();
      end
   end

   // Main sequence
   initial begin
      {rst_n, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {status, output_freq, dc_voltage} = '0;
      det_v = 16'h0bb8;
      band_v = 16'h03e8;
      void'($urandom(54878));
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      ce <= 1'b1;
      apply(19'h7ffff, 16'h0000, 16'h0000);
      chk({14'h0, relay_out}, 16'h0000, "reset codes");
      foreach (t4[i]) begin
         rdr(8'(i * 4));
         e = 2'b00;
         chk(rd, i == 0 ? 16'h001d : i == 1 ? 16'h000e : i == 2 ? 16'h0000 :
            i == 3 ? 16'h0bb8 : i == 4 ? 16'h03e8 : i == 5 ? 16'hffff : 16'h0000, "reset");
      end
      $display("test reset done");
      // Code 4 with new detection settings: 2000, band 600, decel level 1700
      wr(8'h0c, 16'd2000);
      wr(8'h10, 16'd600);
      det_v = 16'd2000;
      band_v = 16'd600;
      rdr(8'h0c);
      chk(rd, 16'd2000, "det freq");
      rdr(8'h10);
      chk(rd, 16'd600, "det band");
      wr(8'h00, 16'd4);
      t4 = '{{3'b010, 16'd1999}, {3'b110, 16'd2000}, {3'b100, 16'd100}, {3'b101, 16'd1701},
         {3'b001, 16'd1700}, {3'b000, 16'd9000}, {3'b101, 16'd1800}, {3'b010, 16'd1000}};
      foreach (t4[i]) begin
         s = 19'($urandom);
         s.accelerating = t4[i][17];
         s.decelerating = t4[i][16];
         apply(s, t4[i][15:0], 16'h0000);
         chk({15'h0, relay_out[0]}, {15'h0, t4[i][18]}, "code 4");
      end
      $display("test frequency detect done");
      // Select range edges, read-only monitor, frozen clock enable
      wr(8'h00, 16'd45);
      wr(8'h00, 16'd46);
      wr(8'h00, 16'h0045);
      rdr(8'h00);
      chk(rd, 16'd45, "select range");
      @(posedge sys_clk);
      ce <= 1'b0;
      wr(8'h00, 16'd5);
      ce <= 1'b1;
      rdr(8'h00);
      chk(rd, 16'd45, "ce low write");
      wr(8'h08, 16'h0003);
      rdr(8'h08);
      e = {exp_rel(6'd14, status, output_freq), 1'b0};
      chk(rd, {14'h0, e}, "monitor read only");
      $display("test select range done");
      // Every code but code 4 against random conditions
      for (int c = 0; c <= 45; c++) begin
         if (c == 4) continue;
         c2 = (c == 20) ? 6'd20 : 6'($urandom_range(45, 5));
         lvl = 16'($urandom);
         wr(8'h00, 16'(c));
         wr(8'h04, {10'h000, c2});
         wr(8'h14, lvl);
         repeat (3) begin
            apply(19'($urandom), 16'($urandom_range(4000, 0)), 16'($urandom));
            e = {exp_rel(c2, status, output_freq), exp_rel(6'(c), status, output_freq)};
            chk({14'h0, relay_out}, {14'h0, e}, "relays");
            chk({15'h0, brake_enable}, {15'h0, status.output_active & (dc_voltage > lvl)},
               "brake");
         end
         rdr(8'h08);
         chk(rd, {14'h0, e}, "monitor");
         chk({14'h0, contact}, {14'h0, e}, "contacts");
      end
      $display("test code sweep done");
      // Reset in mid-run returns settings and relays to their reset state
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({14'h0, relay_out}, 16'h0000, "relays in reset");
      rst_n <= 1'b1;
      rdr(8'h00);
      chk(rd, 16'h001d, "mid reset select");
      rdr(8'h0c);
      chk(rd, 16'h0bb8, "mid reset detect");
      $display("test mid reset done");
      complete_run();
   end
endmodule // tb
`default_nettype wire
